// >>> hdl/osc_trim_and_calibration.sv
`timescale 1ns/100ps
// Operation
// (R1) 2048 trim steps; code 0x000 slowest, 0x7ff fastest
// (R2) Low eight trim bits drive eight binary capacitor switches directly
// (R3) Top three bits decode to seven thermometer switches; 0 and 1 both set one
// (R4) Software changes coarse bits one step at a time, about 200 us apart
// (R5) After crystal enable, count trim delay in 250 us units, then flag and apply
// (R6) Zero trim delay applies the trim code at once on start-up
// (R7) After trim applied, count settle delay in 250 us units, then flag settled
// (R8) Select codes 4, 5, 6, 7 pick slow RC, fast RC, slow crystal, enhanced RC
// (R9) On completion the start bit clears and a 32-bit result is held
// (R10) Result counts fast crystal cycles over N measured-clock periods
// (R11) Software repeats enhanced RC measurement every active connection period
// (R12) Fast RC tune resets to its minimum setting
// (R13) Crystal disable clears both flags; counters restart at the next enable
module osc_trim_and_calibration #(
	parameter int unsigned UNIT_CYCLES = osc_trim_pkg::UNIT_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic trim_wr,
	input wire logic [osc_trim_pkg::TRIM_W-1:0] trim_wdata,
	input wire logic xtal_enable,
	input wire logic [osc_trim_pkg::DELAY_W-1:0] trim_delay,
	input wire logic [osc_trim_pkg::DELAY_W-1:0] settle_delay,
	input wire logic rc_tune_wr,
	input wire logic [osc_trim_pkg::RC_TUNE_W-1:0] rc_tune_wdata,
	input wire logic meas_sel_wr,
	input wire logic [osc_trim_pkg::SEL_W-1:0] meas_sel_wdata,
	input wire logic [osc_trim_pkg::PERIOD_W-1:0] measure_period_count,
	input wire logic slow_crystal,
	input wire logic fast_rc_osc,
	input wire logic slow_rc_osc,
	input wire logic enhanced_rc_osc,
	input wire logic fast_crystal_tick,
	output logic [osc_trim_pkg::TRIM_W-1:0] crystal_trim_code,
	output logic [osc_trim_pkg::FINE_W-1:0] fine_cap_sw,
	output logic [osc_trim_pkg::COARSE_W-1:0] coarse_cap_sw,
	output logic trim_applied_flag,
	output logic xtal_settled,
	output logic [osc_trim_pkg::RC_TUNE_W-1:0] fast_rc_tune,
	output logic meas_busy,
	output logic [osc_trim_pkg::SEL_W-1:0] meas_sel_code,
	output logic [osc_trim_pkg::RESULT_HALF-1:0] measure_result_high,
	output logic [osc_trim_pkg::RESULT_HALF-1:0] measure_result_low
);
	localparam int unsigned UNIT_W = $clog2(UNIT_CYCLES + 1);
	localparam logic [UNIT_W-1:0] UNIT_LAST = UNIT_W'(UNIT_CYCLES - 1);

	typedef struct packed {
		osc_trim_pkg::seq_state_t st;
		logic [UNIT_W-1:0] unit_cnt;
		logic [osc_trim_pkg::DELAY_W-1:0] ivl;
		logic [osc_trim_pkg::DELAY_W-1:0] tdly;
		logic [osc_trim_pkg::DELAY_W-1:0] sdly;
		logic [osc_trim_pkg::TRIM_W-1:0] stored;
		logic [osc_trim_pkg::TRIM_W-1:0] applied;
		logic [osc_trim_pkg::FINE_W-1:0] fine;
		logic [osc_trim_pkg::COARSE_W-1:0] coarse;
		logic ready;
		logic settled;
		logic [osc_trim_pkg::RC_TUNE_W-1:0] rc;
	} trim_state_t;

	trim_state_t st_r;
	trim_state_t st_nxt;
	logic unit_done;
	logic [osc_trim_pkg::RESULT_W-1:0] meas_result;

	// Input n lights the lowest max(n,1) switches
	function automatic logic [osc_trim_pkg::COARSE_W-1:0] therm(
		input logic [osc_trim_pkg::COARSE_IN_W-1:0] n);
		for (int i = 0; i < osc_trim_pkg::COARSE_W; i++) begin
			therm[i] = (i == 0) || (i < int'(n));
		end
	endfunction : therm

	////////////////////////////////////////////////////////////////////////////////
	assign unit_done = (st_r.unit_cnt == UNIT_LAST);

	always_comb begin
		st_nxt = st_r;
		if (trim_wr) begin
			st_nxt.stored = trim_wdata; // R1
		end
		if (rc_tune_wr) begin
			st_nxt.rc = rc_tune_wdata;
		end
		if (!xtal_enable) begin
			st_nxt.st = osc_trim_pkg::SEQ_OFF; // R13
			st_nxt.ready = 1'b0; // R13
			st_nxt.settled = 1'b0; // R13
			st_nxt.unit_cnt = '0;
			st_nxt.ivl = '0;
		end else begin
			case (st_r.st)
				osc_trim_pkg::SEQ_OFF: begin
					// Delays are latched so a mid-wait rewrite cannot skew timing
					st_nxt.tdly = trim_delay;
					st_nxt.sdly = settle_delay;
					st_nxt.unit_cnt = '0;
					st_nxt.ivl = '0;
					if (trim_delay == osc_trim_pkg::DELAY_NONE) begin
						st_nxt.ready = 1'b1; // R6
						st_nxt.st = osc_trim_pkg::SEQ_SETTLE_WAIT;
					end else begin
						st_nxt.st = osc_trim_pkg::SEQ_TRIM_WAIT;
					end
				end
				osc_trim_pkg::SEQ_TRIM_WAIT: begin
					st_nxt.unit_cnt = unit_done ? '0 : st_r.unit_cnt + 1'b1; // R5
					if (unit_done) begin
						st_nxt.ivl = st_r.ivl + 4'h1;
						if (st_r.ivl + 4'h1 == st_r.tdly) begin
							st_nxt.ready = 1'b1; // R5
							st_nxt.ivl = '0;
							st_nxt.st = osc_trim_pkg::SEQ_SETTLE_WAIT;
						end
					end
				end
				osc_trim_pkg::SEQ_SETTLE_WAIT: begin
					if (st_r.sdly == osc_trim_pkg::DELAY_NONE) begin
						st_nxt.settled = 1'b1; // R7
						st_nxt.st = osc_trim_pkg::SEQ_SETTLED;
					end else begin
						st_nxt.unit_cnt = unit_done ? '0 : st_r.unit_cnt + 1'b1; // R7
						if (unit_done) begin
							st_nxt.ivl = st_r.ivl + 4'h1;
							if (st_r.ivl + 4'h1 == st_r.sdly) begin
								st_nxt.settled = 1'b1; // R7
								st_nxt.st = osc_trim_pkg::SEQ_SETTLED;
							end
						end
					end
				end
				osc_trim_pkg::SEQ_SETTLED: begin
					st_nxt.settled = 1'b1;
				end
				default: begin
					st_nxt.st = osc_trim_pkg::SEQ_OFF;
				end
			endcase
		end
		// Once trimmed, later writes reach the capacitor banks directly
		if (st_nxt.ready) begin
			st_nxt.applied = st_nxt.stored; // R5
		end
		st_nxt.fine = st_nxt.applied[osc_trim_pkg::FINE_LSB +: osc_trim_pkg::FINE_W]; // R2
		st_nxt.coarse = therm(st_nxt.applied[osc_trim_pkg::COARSE_LSB +:
			osc_trim_pkg::COARSE_IN_W]); // R3
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_r <= '{st: osc_trim_pkg::SEQ_OFF, unit_cnt: '0, ivl: '0, tdly: '0, sdly: '0,
				stored: osc_trim_pkg::TRIM_STORED_RESET,
				applied: osc_trim_pkg::TRIM_APPLIED_RESET,
				fine: osc_trim_pkg::TRIM_APPLIED_RESET[7:0],
				coarse: 7'h01, ready: 1'b0, settled: 1'b0,
				rc: osc_trim_pkg::RC_TUNE_RESET}; // R12
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fast RC is sampled at 20 MHz, so its edges alias; use long N for it
	osc_ref_counter u_ref_counter (
		.ref_clk(ref_clk),
		.rst(rst),
		.sel_wr(meas_sel_wr),
		.sel_wdata(meas_sel_wdata),
		.measure_period_count(measure_period_count),
		.slow_crystal(slow_crystal),
		.fast_rc_osc(fast_rc_osc),
		.slow_rc_osc(slow_rc_osc),
		.enhanced_rc_osc(enhanced_rc_osc),
		.fast_crystal_tick(fast_crystal_tick),
		.busy(meas_busy),
		.sel_code(meas_sel_code),
		.result(meas_result)
	);

	assign measure_result_high = meas_result[osc_trim_pkg::RESULT_W-1:osc_trim_pkg::RESULT_HALF];
	assign measure_result_low = meas_result[osc_trim_pkg::RESULT_HALF-1:0];
	assign crystal_trim_code = st_r.stored;
	assign fine_cap_sw = st_r.fine;
	assign coarse_cap_sw = st_r.coarse;
	assign trim_applied_flag = st_r.ready;
	assign xtal_settled = st_r.settled;
	assign fast_rc_tune = st_r.rc;

	////////////////////////////////////////////////////////////////////////////////
	logic [31:0] wait_cycles_r;

	always_ff @(posedge ref_clk) begin
		if (rst || st_r.st == osc_trim_pkg::SEQ_OFF) begin
			wait_cycles_r <= '0;
		end else if (st_r.st == osc_trim_pkg::SEQ_TRIM_WAIT) begin
			wait_cycles_r <= wait_cycles_r + 32'h1;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	chk_fine_direct: assert property (fine_cap_sw == st_r.applied[7:0] && // R1 R2
		(st_r.applied == osc_trim_pkg::TRIM_MAX_FREQ) == (&{fine_cap_sw, coarse_cap_sw}))
		else $error("fine switches differ from applied code");
	chk_coarse_therm: assert property (coarse_cap_sw[0] && // R3
		$countones(coarse_cap_sw) == ((st_r.applied[10:8] == 3'h0) ? 1 : int'(st_r.applied[10:8])))
		else $error("coarse switches not a thermometer of applied code");
	chk_trim_delay: assert property ($rose(trim_applied_flag) |-> // R5
		wait_cycles_r == 32'(st_r.tdly) * 32'(UNIT_CYCLES))
		else $error("trim applied at wrong time");
	chk_apply_code: assert property ($rose(trim_applied_flag) |-> // R5
		st_r.applied == st_r.stored)
		else $error("stored code not applied at trim ready");
	chk_zero_delay: assert property (st_r.st == osc_trim_pkg::SEQ_OFF && xtal_enable && // R6
		trim_delay == osc_trim_pkg::DELAY_NONE |=> trim_applied_flag)
		else $error("zero trim delay did not apply at once");
	chk_settle_order: assert property ($rose(xtal_settled) |-> $past(trim_applied_flag)) // R7
		else $error("settled raised before trim applied");
	chk_disable_clears: assert property (!xtal_enable |=> // R13
		!trim_applied_flag && !xtal_settled && st_r.unit_cnt == '0)
		else $error("disable did not clear flags");
	chk_rc_reset: assert property ($fell(rst) |-> // R12
		fast_rc_tune == osc_trim_pkg::RC_TUNE_RESET)
		else $error("fast RC tune not at minimum after reset");

	cov_trimmed: cover property ($rose(trim_applied_flag) && st_r.tdly != '0);
	cov_settled: cover property ($rose(xtal_settled));
	cov_full_coarse: cover property (coarse_cap_sw == 7'h7f);
endmodule : osc_trim_and_calibration

// >>> inc/osc_trim_pkg.sv
package osc_trim_pkg;
	// Reference clock
	localparam int unsigned REF_CLK_HZ = 20_000_000;
	localparam int unsigned REF_CLK_MHZ = REF_CLK_HZ / 1_000_000;
	// Sequencer interval unit, 250 us
	localparam int unsigned UNIT_TIME_NS = 250_000;
	localparam int unsigned UNIT_CYCLES = (UNIT_TIME_NS * REF_CLK_MHZ) / 1000;
	// Recommended coarse-step spacing for software, 200 us
	localparam int unsigned COARSE_STEP_NS = 200_000;
	localparam int unsigned COARSE_STEP_CYCLES = (COARSE_STEP_NS * REF_CLK_MHZ) / 1000;
	// Crystal trim code layout
	localparam int unsigned TRIM_W = 11;
	localparam int unsigned FINE_W = 8;
	localparam int unsigned COARSE_IN_W = 3;
	localparam int unsigned COARSE_W = 7;
	localparam int unsigned FINE_LSB = 0;
	localparam int unsigned COARSE_LSB = 8;
	localparam logic [10:0] TRIM_MIN_FREQ = 11'h000;
	localparam logic [10:0] TRIM_MAX_FREQ = 11'h7ff;
	localparam logic [10:0] TRIM_STORED_RESET = 11'h400;
	localparam logic [10:0] TRIM_APPLIED_RESET = 11'h000;
	// Trim sequencer delay fields
	localparam int unsigned DELAY_W = 4;
	localparam logic [3:0] DELAY_NONE = 4'h0;
	// Reference counter
	localparam int unsigned SEL_W = 16;
	localparam int unsigned PERIOD_W = 16;
	localparam int unsigned RESULT_W = 32;
	localparam int unsigned RESULT_HALF = 16;
	localparam logic [15:0] SEL_RESET = 16'h0000;
	localparam logic [15:0] SEL_SLOW_RC = 16'h0004;
	localparam logic [15:0] SEL_FAST_RC = 16'h0005;
	localparam logic [15:0] SEL_SLOW_CRYSTAL = 16'h0006;
	localparam logic [15:0] SEL_ENH_RC = 16'h0007;
	// Fast RC tune, resets to slowest setting
	localparam int unsigned RC_TUNE_W = 4;
	localparam logic [3:0] RC_TUNE_RESET = 4'h0;

	typedef enum logic [1:0] {
		SEQ_OFF,
		SEQ_TRIM_WAIT,
		SEQ_SETTLE_WAIT,
		SEQ_SETTLED
	} seq_state_t;
endpackage : osc_trim_pkg

// >>> hdl/osc_ref_counter.sv
`timescale 1ns/100ps
module osc_ref_counter (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic sel_wr,
	input wire logic [osc_trim_pkg::SEL_W-1:0] sel_wdata,
	input wire logic [osc_trim_pkg::PERIOD_W-1:0] measure_period_count,
	input wire logic slow_crystal,
	input wire logic fast_rc_osc,
	input wire logic slow_rc_osc,
	input wire logic enhanced_rc_osc,
	input wire logic fast_crystal_tick,
	output logic busy,
	output logic [osc_trim_pkg::SEL_W-1:0] sel_code,
	output logic [osc_trim_pkg::RESULT_W-1:0] result
);
	typedef struct packed {
		logic busy;
		logic armed;
		logic prev;
		logic [osc_trim_pkg::SEL_W-1:0] sel;
		logic [osc_trim_pkg::PERIOD_W-1:0] periods;
		logic [osc_trim_pkg::RESULT_W-1:0] count;
		logic [osc_trim_pkg::RESULT_W-1:0] result;
	} ref_state_t;

	ref_state_t st_r;
	ref_state_t st_nxt;
	logic sample;
	logic rise;

	function automatic logic valid_sel(input logic [osc_trim_pkg::SEL_W-1:0] code);
		valid_sel = (code == osc_trim_pkg::SEL_SLOW_RC) || (code == osc_trim_pkg::SEL_FAST_RC) ||
			(code == osc_trim_pkg::SEL_SLOW_CRYSTAL) || (code == osc_trim_pkg::SEL_ENH_RC);
	endfunction : valid_sel

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		case (st_r.sel) // R8
			osc_trim_pkg::SEL_SLOW_RC: sample = slow_rc_osc;
			osc_trim_pkg::SEL_FAST_RC: sample = fast_rc_osc;
			osc_trim_pkg::SEL_SLOW_CRYSTAL: sample = slow_crystal;
			osc_trim_pkg::SEL_ENH_RC: sample = enhanced_rc_osc;
			default: sample = 1'b0;
		endcase
	end

	assign rise = sample & ~st_r.prev;

	always_comb begin
		st_nxt = st_r;
		st_nxt.prev = sample;
		if (sel_wr) begin
			// A new select abandons any measurement in flight and starts a new one only for a valid code
			st_nxt.sel = sel_wdata;
			// Old select's level is no history for the new clock: block a false first edge
			st_nxt.prev = 1'b1;
			st_nxt.busy = valid_sel(sel_wdata); // R8
			st_nxt.armed = 1'b0;
			st_nxt.periods = '0;
			st_nxt.count = '0;
		end else if (st_r.busy) begin
			if (measure_period_count == '0) begin
				st_nxt.busy = 1'b0;
				st_nxt.result = '0;
			end else if (!st_r.armed) begin
				// First edge only opens the window
				st_nxt.armed = rise;
			end else begin
				st_nxt.count = st_r.count + {31'h0, fast_crystal_tick}; // R10
				if (rise) begin
					st_nxt.periods = st_r.periods + 16'h1;
					if (st_r.periods + 16'h1 == measure_period_count) begin
						st_nxt.busy = 1'b0; // R9
						st_nxt.result = st_nxt.count; // R9
					end
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_r <= '{busy: 1'b0, armed: 1'b0, prev: 1'b0, sel: osc_trim_pkg::SEL_RESET,
				periods: '0, count: '0, result: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign busy = st_r.busy;
	assign sel_code = st_r.sel;
	assign result = st_r.result;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	chk_bad_sel_idle: assert property (sel_wr && !valid_sel(sel_wdata) |=> !busy) // R8
		else $error("invalid select code started a measurement");
	chk_done_clears_busy: assert property ( // R9
		busy && st_r.armed && rise && !sel_wr && measure_period_count != '0 &&
		st_r.periods + 16'h1 == measure_period_count |=> !busy)
		else $error("busy not cleared at measurement end");
	chk_result_count: assert property ($fell(busy) && !$past(sel_wr) && $past(st_r.armed) |-> // R10
		result == $past(st_r.count) + {31'h0, $past(fast_crystal_tick)})
		else $error("result does not match counted crystal ticks");
	cov_measure_done: cover property ($fell(busy) && result != '0);
endmodule : osc_ref_counter

// >>> tb/testbench.sv
`timescale 1ns/100ps
module testbench;
	localparam int U = 4;
	logic ref_clk, rst, trim_wr, xtal_enable, rc_tune_wr, meas_sel_wr, fast_crystal_tick;
	logic [10:0] trim_wdata;
	logic [3:0] trim_delay, settle_delay, rc_tune_wdata;
	logic [15:0] meas_sel_wdata, measure_period_count;
	logic slow_crystal, fast_rc_osc, slow_rc_osc, enhanced_rc_osc;
	logic [10:0] crystal_trim_code;
	logic [7:0] fine_cap_sw;
	logic [6:0] coarse_cap_sw;
	logic trim_applied_flag, xtal_settled, meas_busy;
	logic [3:0] fast_rc_tune;
	logic [15:0] meas_sel_code, measure_result_high, measure_result_low;
	int num_errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic [31:0] seed = 32'hfd82;

	osc_trim_and_calibration #(.UNIT_CYCLES(U)) dut_u (.ref_clk(ref_clk), .rst(rst),
		.trim_wr(trim_wr), .trim_wdata(trim_wdata), .xtal_enable(xtal_enable),
		.trim_delay(trim_delay), .settle_delay(settle_delay), .rc_tune_wr(rc_tune_wr),
		.rc_tune_wdata(rc_tune_wdata), .meas_sel_wr(meas_sel_wr),
		.meas_sel_wdata(meas_sel_wdata), .measure_period_count(measure_period_count),
		.slow_crystal(slow_crystal), .fast_rc_osc(fast_rc_osc), .slow_rc_osc(slow_rc_osc),
		.enhanced_rc_osc(enhanced_rc_osc), .fast_crystal_tick(fast_crystal_tick),
		.crystal_trim_code(crystal_trim_code), .fine_cap_sw(fine_cap_sw),
		.coarse_cap_sw(coarse_cap_sw), .trim_applied_flag(trim_applied_flag),
		.xtal_settled(xtal_settled), .fast_rc_tune(fast_rc_tune), .meas_busy(meas_busy),
		.meas_sel_code(meas_sel_code), .measure_result_high(measure_result_high),
		.measure_result_low(measure_result_low));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// Select code k sees a clock of period k+2 cycles, so a wrong pick changes the count
	always @(negedge ref_clk) cyc <= cyc + 1;
	assign slow_rc_osc = (cyc % 6) < 3;
	assign fast_rc_osc = (cyc % 7) < 3;
	assign slow_crystal = (cyc % 8) < 4;
	assign enhanced_rc_osc = (cyc % 9) < 4;
	// Ticks on four cycles of five, so counting cycles instead of ticks shows up
	assign fast_crystal_tick = (cyc % 5) != 4;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	function automatic logic [6:0] therm(input logic [2:0] n);
		return (n == 3'h0) ? 7'h01 : (7'h7f >> (3'h7 - n));
	endfunction : therm

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// Arming edge and tick phase are free, so one tick either way is allowed
	task automatic chk_near(input logic [31:0] got, input logic [31:0] exp, input string what);
		logic [31:0] d;
		d = got - exp;
		samples_checked++;
		if (!(d === 32'h0 || d === 32'h1 || d === 32'hffffffff)) begin
			num_errors++;
			$display("ERROR %0t: %s got %h expected about %h", $time, what, got, exp);
		end
	endtask : chk_near

	task automatic wr_trim(input logic [10:0] v);
		trim_wdata = v;
		trim_wr = 1'b1;
		@(negedge ref_clk);
		trim_wr = 1'b0;
	endtask : wr_trim

	task automatic chk_sw(input logic [10:0] v);
		chk({21'h0, crystal_trim_code}, {21'h0, v}, "trim readback");
		chk({24'h0, fine_cap_sw}, {24'h0, v[7:0]}, "fine switches");
		chk({25'h0, coarse_cap_sw}, {25'h0, therm(v[10:8])}, "coarse switches");
	endtask : chk_sw

	task automatic seq_run(input logic [3:0] d, input logic [3:0] s, input logic [10:0] v);
		int cnt;
		trim_delay = d;
		settle_delay = s;
		xtal_enable = 1'b1;
		cnt = 0;
		while (trim_applied_flag !== 1'b1 && cnt < 300) begin
			@(negedge ref_clk);
			cnt++;
		end
		chk(cnt, 1 + d * U, "trim ready delay");
		chk_sw(v);
		cnt = 0;
		while (xtal_settled !== 1'b1 && cnt < 300) begin
			@(negedge ref_clk);
			cnt++;
		end
		chk(cnt, (s == 4'h0) ? 1 : s * U, "settle delay");
		xtal_enable = 1'b0;
		repeat (2) @(negedge ref_clk);
		chk({30'h0, trim_applied_flag, xtal_settled}, 32'h0, "flags after disable");
	endtask : seq_run

	task automatic measure(input logic [15:0] k, input logic [15:0] n);
		int cnt;
		measure_period_count = n;
		meas_sel_wdata = k;
		meas_sel_wr = 1'b1;
		@(negedge ref_clk);
		meas_sel_wr = 1'b0;
		chk({31'h0, meas_busy}, 32'h1, "start bit set");
		chk({16'h0, meas_sel_code}, {16'h0, k}, "select readback");
		cnt = 0;
		while (meas_busy !== 1'b0 && cnt < 400) begin
			@(negedge ref_clk);
			cnt++;
		end
		chk({31'h0, meas_busy}, 32'h0, "start bit cleared");
		chk_near({measure_result_high, measure_result_low}, (n * (k + 16'h2) * 4) / 5,
			"result");
	endtask : measure

	task automatic wrap_up();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (80000) @(posedge ref_clk);
		num_errors++;
		$display("ERROR %0t: watchdog expired", $time);
		wrap_up();
	end

	initial begin
		logic [10:0] v;
		logic [3:0] t;
		{rst, trim_wr, xtal_enable, rc_tune_wr, meas_sel_wr} = 5'b10000;
		{trim_wdata, trim_delay, settle_delay, rc_tune_wdata} = '0;
		{meas_sel_wdata, measure_period_count} = '0;
		repeat (20) @(negedge ref_clk);
		rst = 1'b0;
		chk({28'h0, fast_rc_tune}, 32'h0, "fast rc tune reset");
		chk({21'h0, crystal_trim_code}, 32'h0000_0400, "stored trim reset");
		chk({17'h0, fine_cap_sw, coarse_cap_sw}, 32'h1, "switch reset");
		chk({29'h0, trim_applied_flag, xtal_settled, meas_busy}, 32'h0, "status reset");
		t = 4'(rnd());
		rc_tune_wdata = t;
		rc_tune_wr = 1'b1;
		@(negedge ref_clk);
		rc_tune_wr = 1'b0;
		chk({28'h0, fast_rc_tune}, {28'h0, t}, "fast rc tune write");
		$display("test reset done");
		// Switches must hold until the sequencer applies the code
		v = 11'(rnd());
		wr_trim(v);
		chk({21'h0, crystal_trim_code}, {21'h0, v}, "stored before ready");
		chk({17'h0, fine_cap_sw, coarse_cap_sw}, 32'h1, "held before ready");
		seq_run(4'(1 + rnd() % 4), 4'(1 + rnd() % 3), v);
		seq_run(4'h0, 4'h0, v);
		$display("test sequencer done");
		xtal_enable = 1'b1;
		for (int k = 0; k < 8; k++) begin
			v = {k[2:0], (k == 0) ? 8'h00 : (k == 7) ? 8'hff : 8'(rnd())};
			wr_trim(v);
			chk_sw(v);
			repeat (osc_trim_pkg::COARSE_STEP_CYCLES) @(negedge ref_clk);
		end
		// Back to back: the strobe stays up across both writes
		trim_wdata = 11'h6ff;
		trim_wr = 1'b1;
		@(negedge ref_clk);
		wr_trim(11'h7a5);
		chk_sw(11'h7a5);
		$display("test trim decode done");
		for (int k = 4; k < 8; k++) measure(k[15:0], 16'(2 + rnd() % 4));
		measure(16'h7, 16'h3);
		measure(16'h6, 16'h0);
		meas_sel_wdata = 16'h3;
		meas_sel_wr = 1'b1;
		@(negedge ref_clk);
		meas_sel_wr = 1'b0;
		@(negedge ref_clk);
		chk({15'h0, meas_busy, meas_sel_code}, 32'h3, "invalid select");
		$display("test measurement done");
		wrap_up();
	end
endmodule : testbench
